// [hw/osp_consts.vh]
/*
 constants for the one-shot / pwm timer: apb register offsets, field positions,
 reset values and mode encodings. definitions only.
*/
`ifndef OSP_CONSTS_VH
`define OSP_CONSTS_VH
// register byte offsets
`define OSP_REG_CTRL 12'h000
`define OSP_REG_TIMER 12'h004
`define OSP_REG_START 12'h008
`define OSP_REG_STATUS 12'h00c
`define OSP_REG_MASK 12'h010
`define OSP_REG_STATE 12'h014
// ctrl fields
`define OSP_CTRL_PWM 0
`define OSP_CTRL_PWM8 1
`define OSP_CTRL_SRC_LO 2
`define OSP_CTRL_SRC_HI 3
`define OSP_CTRL_TRIG_EN 4
`define OSP_CTRL_OVF_EN 5
`define OSP_CTRL_OUT_EN 6
`define OSP_CTRL_TRIG_FALL 7
`define OSP_CTRL_W 8
// start register fields
`define OSP_START_COUNT 0
`define OSP_START_ONESHOT 1
`define OSP_START_GPIO 2
// status fields
`define OSP_ST_ZERO 0
`define OSP_ST_FALL 1
`define OSP_ST_W 2
// clock sources
`define OSP_SRC_DIV1 2'h0
`define OSP_SRC_DIV8 2'h1
`define OSP_SRC_DIV32 2'h2
`define OSP_SRC_SUB32 2'h3
`define OSP_DIV8 6'h08
`define OSP_DIV32 6'h20
// misc
`define OSP_ZERO16 16'h0000
`define OSP_ONE16 16'h0001
`define OSP_ZERO8 8'h00
`define OSP_ONE8 8'h01
`define OSP_PERIOD16 16'hffff
`define OSP_PERIOD8 8'hff
`define OSP_UNDEF_READ 32'hdeadbeef
`endif

// [hw/osp_clkdiv.v]
/*
 enable divider: one-cycle pulse every div_val enables of en_in.
 assumes a single clock; en_in already one cycle wide.
*/
`timescale 1ns/1ps
module osp_clkdiv
(
   input wire clock, // system clock
   input wire reset, // async reset, active high
   input wire en_in, // input enable
   input wire [5:0] div_val, // division ratio
   output reg en_out // divided enable pulse
);
   reg [5:0] cnt_r;
   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         cnt_r <= 6'h00;
         en_out <= 1'b0;
      end
      else
      begin
         en_out <= 1'b0;
         if (en_in)
         begin
            if (cnt_r == div_val - 6'h01)
            begin
               cnt_r <= 6'h00;
               en_out <= 1'b1;
            end
            else
               cnt_r <= cnt_r + 6'h01;
         end
      end
   end
endmodule // osp_clkdiv

// [hw/osp_timer.v]
/*
 one-shot and pwm down-counting timer with apb register access.
 assumes inputs synchronous to clock; subclock_tick is a one-cycle pulse per
 sub-clock period; timer_overflow_in a one-cycle pulse from another timer.
*/
// Operation
// - one-shot counts down, reloads at zero, stops
// - one-shot trigger while running reloads, restarts
// - one-shot starts on pin, overflow, or flag
// - clearing count start flag stops counter
// - one-shot interrupt when count reaches zero
// - input pin is gpio or trigger
// - one-shot output pin is gpio or pulse
// - timer register read returns undefined value
// - write while stopped loads reload and counter
// - write while counting loads reload only
// - pwm mode counts down, 8 or 16 bit
// - pwm reloads at output rising edge, continues
// - pwm ignores triggers once counting
// - 16-bit pwm: high n, period 65535
// - 8-bit pwm: high n(m+1), period 255(m+1)
// - pwm starts on pin, overflow, or flag
`timescale 1ns/1ps
`include "osp_consts.vh"
module osp_timer
(
   input wire clock, // 125 mhz system clock
   input wire reset, // async reset, active high
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error
   input wire subclock_tick, // sub-clock period pulse
   input wire timer_overflow_in, // overflow of selected internal timer
   input wire timer_trigger_in_pin, // input pin level
   output reg gpio_in_r, // input pin as gpio
   output reg timer_pulse_out_pin, // output pin level
   output reg timer_pulse_out_oe, // output pin drive enable
   output reg irq // level interrupt
);
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;

   reg [`OSP_CTRL_W-1:0] ctrl_r;
   reg [15:0] reload_r;
   reg [15:0] count_r;
   reg count_start_r;
   reg state_r;
   reg out_r;
   reg [7:0] pre_r;
   reg [15:0] ph_r;
   reg [`OSP_ST_W-1:0] status_r;
   reg [`OSP_ST_W-1:0] mask_r;
   reg gpio_out_r;
   reg trig_d_r;

   // =========================================================
   // count clock selection
   wire en_div8;
   wire en_div32;
   wire en_sub32;
   reg selected_count_clock;
   osp_clkdiv u_div8
   (
      .clock(clock),
      .reset(reset),
      .en_in(1'b1),
      .div_val(`OSP_DIV8),
      .en_out(en_div8)
   );
   osp_clkdiv u_div32
   (
      .clock(clock),
      .reset(reset),
      .en_in(1'b1),
      .div_val(`OSP_DIV32),
      .en_out(en_div32)
   );
   // sub-clock ticks are already slow; divide them again by 32
   osp_clkdiv u_sub32
   (
      .clock(clock),
      .reset(reset),
      .en_in(subclock_tick),
      .div_val(`OSP_DIV32),
      .en_out(en_sub32)
   );
   // div1 source counts on every clock
   always @*
   begin
      case (ctrl_r[`OSP_CTRL_SRC_HI:`OSP_CTRL_SRC_LO])
         `OSP_SRC_DIV1: selected_count_clock = 1'b1;
         `OSP_SRC_DIV8: selected_count_clock = en_div8;
         `OSP_SRC_DIV32: selected_count_clock = en_div32;
         default: selected_count_clock = en_sub32;
      endcase
   end

   // =========================================================
   // apb decode
   // writes land at the access edge, while pready stands high
   wire wr = psel & penable & pwrite & pready;
   wire rd_setup = psel & ~penable & ~pwrite;
   wire wr_ctrl = wr & (paddr == `OSP_REG_CTRL);
   wire wr_timer = wr & (paddr == `OSP_REG_TIMER);
   wire wr_start = wr & (paddr == `OSP_REG_START);
   wire wr_status = wr & (paddr == `OSP_REG_STATUS);
   wire wr_mask = wr & (paddr == `OSP_REG_MASK);
   wire mapped = (paddr == `OSP_REG_CTRL) ||
      (paddr == `OSP_REG_TIMER) ||
      (paddr == `OSP_REG_START) ||
      (paddr == `OSP_REG_STATUS) ||
      (paddr == `OSP_REG_MASK) ||
      (paddr == `OSP_REG_STATE);

   // =========================================================
   // start events
   wire pwm = ctrl_r[`OSP_CTRL_PWM];
   wire pwm8 = ctrl_r[`OSP_CTRL_PWM8];
   // pin edge against the registered copy; copy resets to the idle low level
   wire trig_edge = ctrl_r[`OSP_CTRL_TRIG_FALL] ? (trig_d_r & ~timer_trigger_in_pin) :
      (~trig_d_r & timer_trigger_in_pin);
   wire ext_trig = ctrl_r[`OSP_CTRL_TRIG_EN] & trig_edge;
   wire ovf_trig = ctrl_r[`OSP_CTRL_OVF_EN] & timer_overflow_in;
   wire sw_os = wr_start & pwdata[`OSP_START_ONESHOT];
   // pwm also starts on the count start flag going from 0 to 1
   wire pwm_sw_start = wr_start & pwdata[`OSP_START_COUNT] & ~count_start_r;
   wire start_nxt = wr_start ? pwdata[`OSP_START_COUNT] : count_start_r;
   // every start event is gated by the count start flag, so a stopped timer ignores it
   wire trigger = start_nxt & (ext_trig | ovf_trig | (pwm ? 1'b0 : sw_os));
   wire [15:0] wval = pwdata[15:0];

   // 8-bit high phase length: n steps of prescaler, n*(m+1) count clocks
   wire [7:0] hi_n = reload_r[15:8];
   wire [7:0] pre_m = reload_r[7:0];
   wire pwm_step = pwm8 ? (pre_r == `OSP_ZERO8) : 1'b1;
   // high and low phase loads, taken from the reload register at each reload
   wire [15:0] hi_load = pwm8 ? {`OSP_ZERO8, hi_n} : reload_r;
   wire [15:0] lo_load = pwm8 ? {`OSP_ZERO8, `OSP_PERIOD8 - hi_n} : `OSP_PERIOD16 - reload_r;

   // =========================================================
   // counter core
   reg ev_zero;
   reg ev_fall;
   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         ctrl_r <= {`OSP_CTRL_W{1'b0}};
         reload_r <= `OSP_ZERO16;
         count_r <= `OSP_ZERO16;
         count_start_r <= 1'b0;
         state_r <= ST_IDLE;
         out_r <= 1'b0;
         pre_r <= `OSP_ZERO8;
         ph_r <= `OSP_ZERO16;
         trig_d_r <= 1'b0;
         ev_zero <= 1'b0;
         ev_fall <= 1'b0;
      end
      else
      begin
         trig_d_r <= timer_trigger_in_pin;
         ev_zero <= 1'b0;
         ev_fall <= 1'b0;
         if (wr_ctrl)
            ctrl_r <= pwdata[`OSP_CTRL_W-1:0];
         count_start_r <= start_nxt;
         // while running only the reload changes; the counter takes it at the next reload
         if (wr_timer)
         begin
            reload_r <= wval;
            if (state_r == ST_IDLE)
               count_r <= wval;
         end
         // stopping drops the pulse at once in both modes
         if (!start_nxt)
         begin
            state_r <= ST_IDLE;
            out_r <= 1'b0;
         end
         else if (!pwm)
         begin
            if (trigger)
            begin
               // a write in the trigger cycle already counts as the new reload
               count_r <= wr_timer ? wval : reload_r;
               state_r <= ST_RUN;
               out_r <= 1'b1;
            end
            else if (state_r == ST_RUN && selected_count_clock)
            begin
               if (count_r <= `OSP_ONE16)
               begin
                  count_r <= wr_timer ? wval : reload_r;
                  state_r <= ST_IDLE;
                  out_r <= 1'b0;
                  ev_zero <= 1'b1;
               end
               else
                  count_r <= count_r - `OSP_ONE16;
            end
         end
         else if (state_r == ST_IDLE)
         begin
            if (trigger | pwm_sw_start)
            begin
               state_r <= ST_RUN;
               out_r <= (hi_load != `OSP_ZERO16);
               count_r <= hi_load;
               ph_r <= lo_load;
               pre_r <= pre_m;
            end
         end
         else if (selected_count_clock)
         begin
            // prescaler gives one step per m+1 count clocks
            pre_r <= (pre_r == `OSP_ZERO8) ? pre_m : pre_r - `OSP_ONE8;
            if (pwm_step)
            begin
               if (out_r)
               begin
                  if (count_r <= `OSP_ONE16)
                  begin
                     out_r <= (ph_r == `OSP_ZERO16);
                     ev_fall <= (ph_r != `OSP_ZERO16);
                     count_r <= `OSP_ZERO16;
                  end
                  else
                     count_r <= count_r - `OSP_ONE16;
               end
               else if (ph_r <= `OSP_ONE16)
               begin
                  out_r <= (hi_load != `OSP_ZERO16);
                  count_r <= hi_load;
                  ph_r <= lo_load;
               end
               else
                  ph_r <= ph_r - `OSP_ONE16;
               // full-width high phase: no low phase, reload at once
               if (out_r && count_r <= `OSP_ONE16 && ph_r == `OSP_ZERO16)
               begin
                  count_r <= hi_load;
                  ph_r <= lo_load;
               end
            end
         end
      end
   end

   // =========================================================
   // interrupt status, mask
   wire [`OSP_ST_W-1:0] ev_vec = {ev_fall, ev_zero};
   wire [`OSP_ST_W-1:0] st_clr = wr_status ? pwdata[`OSP_ST_W-1:0] : {`OSP_ST_W{1'b0}};
   // set wins over clear, so an event in the clearing cycle is not lost
   wire [`OSP_ST_W-1:0] status_nxt = (status_r & ~st_clr) | ev_vec;
   wire [`OSP_ST_W-1:0] mask_nxt = wr_mask ? pwdata[`OSP_ST_W-1:0] : mask_r;
   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         status_r <= {`OSP_ST_W{1'b0}};
         mask_r <= {`OSP_ST_W{1'b0}};
         irq <= 1'b0;
      end
      else
      begin
         status_r <= status_nxt;
         mask_r <= mask_nxt;
         // irq from next values keeps it in step with status reads
         irq <= |(status_nxt & mask_nxt);
      end
   end

   // =========================================================
   // pins
   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         gpio_out_r <= 1'b0;
         gpio_in_r <= 1'b0;
         timer_pulse_out_pin <= 1'b0;
         timer_pulse_out_oe <= 1'b0;
      end
      else
      begin
         gpio_in_r <= timer_trigger_in_pin;
         if (wr_start)
            gpio_out_r <= pwdata[`OSP_START_GPIO];
         // pin always driven: pulse output or gpio output level
         timer_pulse_out_oe <= 1'b1;
         if (pwm || ctrl_r[`OSP_CTRL_OUT_EN])
            timer_pulse_out_pin <= out_r;
         else
            timer_pulse_out_pin <= gpio_out_r;
      end
   end

   // =========================================================
   // apb read and ready
   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         // one access cycle per transfer, no wait states
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         // read data registered at the setup edge, stands in the access cycle
         if (rd_setup)
         begin
            if (paddr == `OSP_REG_CTRL)
               prdata <= {24'h000000, ctrl_r};
            else if (paddr == `OSP_REG_TIMER)
               prdata <= `OSP_UNDEF_READ;
            else if (paddr == `OSP_REG_START)
               prdata <= {29'h00000000, gpio_out_r, 1'b0, count_start_r};
            else if (paddr == `OSP_REG_STATUS)
               prdata <= {30'h00000000, status_r};
            else if (paddr == `OSP_REG_MASK)
               prdata <= {30'h00000000, mask_r};
            else if (paddr == `OSP_REG_STATE)
               prdata <= {15'h0000, state_r, count_r};
            else
               prdata <= 32'h00000000;
         end
      end
   end
endmodule // osp_timer

// [sim/osp_partner.sv]
/* pin-side model: trigger source and pulse width and period meter.
   assumes pins synchronous to clock. */
`timescale 1ns/1ps
module osp_partner
(
   input wire clock, // clock
   input wire out_pin, // pulse in
   output reg trig // trigger out
);
   integer hi = 0, per = 0, hc = 0, pc = 0, rises = 0;
   reg last = 0;
   initial trig = 0;
   // ==========
   // width and period meter
   always @(posedge clock)
   begin
      last <= out_pin;
      hc <= out_pin ? hc + 1 : 0;
      pc <= (out_pin && !last) ? 1 : pc + 1;
      if (!out_pin && last)
         hi <= hc;
      if (out_pin && !last)
      begin
         per <= pc;
         rises <= rises + 1;
      end
   end
   task pulse;
   begin
      trig <= 1;
      @(posedge clock);
      trig <= 0;
   end
   endtask
endmodule // osp_partner

// [sim/osp_timer_sva.sv]
/* port checker for osp_timer.
   assumes an apb master that keeps the protocol. */
`timescale 1ns/1ps
`include "osp_consts.vh"
module osp_timer_sva
(
   input wire clock, // clock
   input wire reset, // reset
   input wire psel, // apb
   input wire penable, // apb
   input wire pwrite, // apb
   input wire [11:0] paddr, // apb
   input wire [31:0] prdata, // apb
   input wire pready, // apb
   input wire pslverr, // apb
   input wire timer_trigger_in_pin, // pin
   input wire gpio_in_r, // pin copy
   input wire timer_pulse_out_oe // pin drive
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // ==========
   // bus and pins
   ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("ready late");
   ready_one_cycle_a: assert property (pready |=> !pready) else $error("ready held");
   ready_has_setup_a: assert property (pready |-> $past(psel && !penable)) else $error("ready unasked");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("error alone");
   err_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
   timer_read_undef_a: assert property (pready && !pwrite && paddr == `OSP_REG_TIMER
      |-> prdata == `OSP_UNDEF_READ) else $error("timer read");
   gpio_follows_pin_a: assert property (!$past(reset)
      |-> gpio_in_r == $past(timer_trigger_in_pin)) else $error("gpio copy");
   out_driven_a: assert property (!$past(reset) |-> timer_pulse_out_oe) else $error("out undriven");
endmodule // osp_timer_sva
bind osp_timer osp_timer_sva SVA (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer_trigger_in_pin(timer_trigger_in_pin), .gpio_in_r(gpio_in_r), .timer_pulse_out_oe(timer_pulse_out_oe));

// [sim/osp_timer_tb.sv]
/* testbench for osp_timer: apb tasks, one-shot, pwm and interrupt tests.
   assumes osp_partner on the pins and the bound checker. */
`timescale 1ns/1ps
`include "osp_consts.vh"
module osp_timer_tb;
   reg clock = 0;
   reg reset = 1;
   reg psel = 0;
   reg penable = 0;
   reg pwrite = 0;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0;
   reg sub_tick = 0;
   reg ovf = 0;
   reg err;
   reg [31:0] rd;
   wire [31:0] prdata;
   wire pready, pslverr, gpio, pin_out, oe, irq, trig;
   integer error_cnt = 0;
   integer check_count = 0;
   integer cyc = 0;
   integer i, t, dv, r;
   osp_timer DUT
   (
      .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .subclock_tick(sub_tick),
      .timer_overflow_in(ovf), .timer_trigger_in_pin(trig), .gpio_in_r(gpio),
      .timer_pulse_out_pin(pin_out), .timer_pulse_out_oe(oe), .irq(irq)
   );
   osp_partner P
   (
      .clock(clock), .out_pin(pin_out), .trig(trig)
   );
   always #4 clock = ~clock;
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      sub_tick <= (cyc % 4 == 3);
      if (cyc == 90000)
      begin
         error_cnt = error_cnt + 1;
         report_and_stop;
      end
   end
   // ==========
   // tasks
   task chk(input [31:0] got, input [31:0] exp);
   begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
   begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clock);
   end
   endtask
   task wirq;
   begin
      t = 0;
      while (irq !== 1'b1 && t < 80000)
      begin
         @(posedge clock);
         t = t + 1;
      end
      // one more edge so the pin meter has taken the falling edge
      @(posedge clock);
      chk(irq, 1);
   end
   endtask
   task wrise(input integer n);
   begin
      t = 0;
      while (P.rises < r + n && t < 70000)
      begin
         @(posedge clock);
         t = t + 1;
      end
   end
   endtask
   task clr;
   begin
      apb(1, `OSP_REG_STATUS, 3);
      apb(0, `OSP_REG_STATUS, 0);
      chk(rd, 0);
      chk(irq, 0);
   end
   endtask
   task report_and_stop;
   begin
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   // ==========
   // tests
   initial
   begin
      repeat (20) @(posedge clock);
      reset <= 0;
      @(posedge clock);
      chk(irq, 0);
      apb(0, `OSP_REG_TIMER, 0);
      chk(rd, `OSP_UNDEF_READ);
      apb(0, 12'h0f0, 0);
      chk(err, 1);
      chk(rd, 0);
      apb(1, `OSP_REG_TIMER, 32'h1234);
      apb(0, `OSP_REG_STATE, 0);
      chk(rd[16:0], 17'h01234);
      apb(1, `OSP_REG_MASK, 3);
      for (i = 0; i < 4; i = i + 1)
      begin
         dv = i == 0 ? 1 : i == 1 ? 8 : i == 2 ? 32 : 128;
         apb(1, `OSP_REG_CTRL, 32'h40 | i << 2);
         apb(1, `OSP_REG_TIMER, 2);
         apb(1, `OSP_REG_START, 3);
         wirq;
         chk(P.hi >= dv && P.hi <= 3 * dv, 1);
         apb(0, `OSP_REG_STATE, 0);
         chk(rd[16:0], 17'h00002);
         clr;
      end
      apb(1, `OSP_REG_CTRL, 32'h50);
      apb(1, `OSP_REG_TIMER, 40);
      P.pulse;
      repeat (20) @(posedge clock);
      P.pulse;
      apb(0, `OSP_REG_STATE, 0);
      chk(rd[16] && rd[15:0] > 30, 1);
      apb(1, `OSP_REG_TIMER, 7);
      apb(0, `OSP_REG_STATE, 0);
      chk(rd[15:0] > 7, 1);
      wirq;
      apb(0, `OSP_REG_STATE, 0);
      chk(rd[16:0], 17'h00007);
      clr;
      apb(1, `OSP_REG_TIMER, 100);
      P.pulse;
      apb(1, `OSP_REG_START, 0);
      apb(0, `OSP_REG_STATE, 0);
      chk(rd[16], 0);
      apb(1, `OSP_REG_CTRL, 32'h60);
      apb(1, `OSP_REG_START, 1);
      ovf <= 1;
      @(posedge clock);
      ovf <= 0;
      wirq;
      clr;
      apb(1, `OSP_REG_START, 0);
      apb(1, `OSP_REG_CTRL, 32'h41);
      apb(1, `OSP_REG_TIMER, 3);
      apb(1, `OSP_REG_START, 1);
      wirq;
      r = P.rises;
      wrise(1);
      chk(P.hi, 3);
      chk(P.per, 65535);
      apb(1, `OSP_REG_START, 0);
      clr;
      apb(1, `OSP_REG_CTRL, 32'h53);
      apb(1, `OSP_REG_TIMER, 32'h0301);
      r = P.rises;
      apb(1, `OSP_REG_START, 1);
      P.pulse;
      wrise(2);
      chk(P.hi, 6);
      chk(P.per, 510);
      wrise(3);
      chk(P.hi, 6);
      chk(P.per, 510);
      apb(1, `OSP_REG_MASK, 0);
      apb(0, `OSP_REG_STATUS, 0);
      chk(rd[1], 1);
      chk(irq, 0);
      apb(1, `OSP_REG_START, 0);
      clr;
      report_and_stop;
   end
endmodule // osp_timer_tb
